// [rtl/irs_top.sv]
// interrupt and reset sequencer with timer for a small 8-bit core
`include "irs_map.svh"
module irs_top (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              reset_pin_n_i,
  input  wire logic              ext_irq_n_i,
  input  wire logic              timer_pin_i,
  input  wire logic              instr_done_i,
  input  wire logic              swi_exec_i,
  input  wire logic              rti_exec_i,
  input  wire logic              cli_i,
  input  wire logic              sei_i,
  input  wire logic [3:0]        bus_addr_i,
  input  wire logic [7:0]        bus_wdata_i,
  input  wire logic              bus_wr_i,
  input  wire logic              bus_rd_i,
  output logic      [7:0]        bus_rdata_o,
  output logic                   mc_tick_o,
  output logic                   cpu_reset_o,
  output logic                   irq_mask_o,
  output logic                   seq_active_o,
  output logic                   stack_push_o,
  output logic                   stack_pop_o,
  output logic      [11:0]       vector_o,
  output logic                   fetch_ok_o
);
  // ****************************************
  // machine cycle enable
  // ****************************************
  localparam int MC_DIV = `IRS_MC_DIV;
  logic [$clog2(MC_DIV)-1:0] div_reg;
  logic                      mc_tick;

  // one enable per machine cycle; the service count and pushes run on it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg <= '0;
    end else if (div_reg == ($clog2(MC_DIV))'(MC_DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign mc_tick = (div_reg == ($clog2(MC_DIV))'(MC_DIV - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mc_tick_o <= 1'b0;
    end else begin
      mc_tick_o <= mc_tick;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic rst_pin_s;
  logic ext_pin_s;
  logic tmr_pin_s;

  irs_sync #(.RST_VAL(1'b0)) u_sync_rst (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (reset_pin_n_i),
    .q_o    (rst_pin_s)
  );
  irs_sync #(.RST_VAL(1'b1)) u_sync_ext (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (ext_irq_n_i),
    .q_o    (ext_pin_s)
  );
  irs_sync #(.RST_VAL(1'b0)) u_sync_tmr (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (timer_pin_i),
    .q_o    (tmr_pin_s)
  );

  // ****************************************
  // reset detector
  // ****************************************
  // a low longer than one machine cycle is caught; shorter glitches
  // between ticks may still be seen, which only resets early
  logic rst_low_reg;
  logic rst_seq;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_low_reg <= 1'b1;
    end else if (!rst_pin_s) begin
      rst_low_reg <= 1'b1;
    end else if (mc_tick) begin
      rst_low_reg <= 1'b0;
    end
  end
  assign rst_seq = rst_low_reg | ~rst_pin_s;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_reset_o <= 1'b1;
    end else begin
      cpu_reset_o <= rst_seq;
    end
  end

  // ****************************************
  // timer pin edge and external latch
  // ****************************************
  logic tmr_prev_reg;
  logic ext_armed_reg;
  logic ext_req_reg;
  logic ext_fall;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_prev_reg <= 1'b0;
    end else begin
      tmr_prev_reg <= tmr_pin_s;
    end
  end

  // armed only after the pin is seen high again
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_armed_reg <= 1'b0;
    end else if (ext_pin_s) begin
      ext_armed_reg <= 1'b1;
    end else begin
      ext_armed_reg <= 1'b0;
    end
  end
  assign ext_fall = ext_armed_reg & ~ext_pin_s;

  // ****************************************
  // timer control bits
  // ****************************************
  logic       tmr_req_reg;
  logic       tmr_mask_reg;
  logic       tmr_ext_reg;
  logic       tmr_stop_reg;
  logic [2:0] presc_sel_reg;
  logic [7:0] count;
  logic       tmr_zero;
  logic       ctrl_wr;
  logic       load_wr;

  assign ctrl_wr = bus_wr_i && bus_addr_i == `IRS_OFS_CTRL;
  assign load_wr = bus_wr_i && bus_addr_i == `IRS_OFS_COUNT;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_req_reg   <= 1'b0;
      tmr_mask_reg  <= 1'b1;
      tmr_ext_reg   <= 1'b0;
      tmr_stop_reg  <= 1'b0;
    end else if (rst_seq) begin
      tmr_req_reg   <= 1'b0;
      tmr_mask_reg  <= 1'b1;
      tmr_ext_reg   <= 1'b0;
      tmr_stop_reg  <= 1'b0;
    end else begin
      if (tmr_zero) begin
        tmr_req_reg <= 1'b1;
      end else if (ctrl_wr && !bus_wdata_i[`IRS_TCR_REQ_BIT]) begin
        tmr_req_reg <= 1'b0;
      end
      if (ctrl_wr) begin
        tmr_mask_reg <= bus_wdata_i[`IRS_TCR_MASK_BIT];
        tmr_ext_reg  <= bus_wdata_i[`IRS_TCR_EXT_BIT];
        tmr_stop_reg <= bus_wdata_i[`IRS_TCR_STOP_BIT];
      end
    end
  end

  // prescaler width is a build option; the division choice is kept writable for flexibility
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presc_sel_reg <= 3'h0;
    end else if (bus_wr_i && bus_addr_i == `IRS_OFS_LOAD) begin
      presc_sel_reg <= bus_wdata_i[2:0];
    end
  end

  irs_timer #(.PRESC_BITS(7)) u_timer (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .rst_seq_i   (rst_seq),
    .mc_tick_i   (mc_tick),
    .ext_tick_i  (tmr_pin_s & ~tmr_prev_reg),
    .ext_sel_i   (tmr_ext_reg),
    .stop_i      (tmr_stop_reg),
    .presc_sel_i (presc_sel_reg),
    .load_i      (load_wr),
    .load_val_i  (bus_wdata_i),
    .count_o     (count),
    .zero_o      (tmr_zero)
  );

  // ****************************************
  // interrupt latches and mask
  // ****************************************
  logic         ext_pend_reg;
  logic         i_bit_reg;
  logic         tmr_pend;
  logic         seq_start;
  irs_pkg::irs_src_t src_reg;
  logic [3:0]   seq_cnt_reg;
  logic         seq_busy;

  assign tmr_pend = tmr_req_reg & ~tmr_mask_reg;
  assign seq_busy = (seq_cnt_reg != 4'h0);

  // held while masked; the new edge wins over the clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_pend_reg <= 1'b0;
    end else if (rst_seq) begin
      ext_pend_reg <= 1'b0;
    end else if (ext_fall) begin
      ext_pend_reg <= 1'b1;
    end else if (seq_start && !i_bit_reg) begin
      ext_pend_reg <= 1'b0;
    end
  end

  // hardware checked only at an instruction boundary
  always_comb begin
    seq_start = 1'b0;
    if (!rst_seq && !seq_busy && instr_done_i) begin
      if (!i_bit_reg && (ext_pend_reg || tmr_pend)) begin
        seq_start = 1'b1;
      end else if (swi_exec_i) begin
        seq_start = 1'b1;
      end
    end
  end

  // source choice: external first, then timer, then the trap
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      src_reg <= irs_pkg::IRS_SRC_EXT;
    end else if (!seq_busy) begin
      if (!i_bit_reg && ext_pend_reg) begin
        src_reg <= irs_pkg::IRS_SRC_EXT;
      end else if (!i_bit_reg && tmr_pend) begin
        src_reg <= irs_pkg::IRS_SRC_TIMER;
      end else begin
        src_reg <= irs_pkg::IRS_SRC_SWI;
      end
    end
  end

  // mask flag: set by reset, service and sei_i, cleared by return and cli_i
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      i_bit_reg <= 1'b1;
    end else if (rst_seq) begin
      i_bit_reg <= 1'b1;
    end else if (seq_start) begin
      i_bit_reg <= 1'b1;
    end else if (rti_exec_i || cli_i) begin
      i_bit_reg <= 1'b0;
    end else if (sei_i) begin
      i_bit_reg <= 1'b1;
    end
  end

  // ****************************************
  // service sequence, counted in machine cycles
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_cnt_reg <= 4'h0;
    end else if (rst_seq) begin
      seq_cnt_reg <= 4'h0;
    end else if (seq_start) begin
      seq_cnt_reg <= 4'(`IRS_SEQ_CYCLES);
    end else if (seq_busy && mc_tick) begin
      seq_cnt_reg <= seq_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_active_o <= 1'b0;
      stack_push_o <= 1'b0;
      stack_pop_o  <= 1'b0;
      vector_o     <= `IRS_VEC_RESET;
      irq_mask_o   <= 1'b1;
      fetch_ok_o   <= 1'b0;
    end else begin
      seq_active_o <= seq_busy;
      stack_push_o <= seq_busy && mc_tick && seq_cnt_reg > 4'h6;
      stack_pop_o  <= rti_exec_i && !rst_seq;
      irq_mask_o   <= i_bit_reg | rst_seq;
      fetch_ok_o   <= !rst_seq && !seq_busy && !seq_start &&
                      (i_bit_reg || !(ext_pend_reg || tmr_pend));
      if (rst_seq) begin
        vector_o <= `IRS_VEC_RESET;
      end else begin
        case (src_reg)
          irs_pkg::IRS_SRC_EXT:   vector_o <= `IRS_VEC_EXT;
          irs_pkg::IRS_SRC_TIMER: vector_o <= `IRS_VEC_TIMER;
          irs_pkg::IRS_SRC_SWI:   vector_o <= `IRS_VEC_SWI;
          default:                vector_o <= `IRS_VEC_SWI;
        endcase
      end
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  // count read has no side effect on counting
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_rdata_o <= 8'h00;
    end else if (bus_rd_i) begin
      case (bus_addr_i)
        `IRS_OFS_CTRL:   bus_rdata_o <= {tmr_req_reg, tmr_mask_reg,
                                         tmr_ext_reg, tmr_stop_reg,
                                         `IRS_TCR_UNUSED};
        `IRS_OFS_COUNT:  bus_rdata_o <= count;
        `IRS_OFS_LOAD:   bus_rdata_o <= {5'h00, presc_sel_reg};
        `IRS_OFS_STATUS: bus_rdata_o <= {4'h0, seq_busy, i_bit_reg,
                                         ext_pend_reg, tmr_pend};
        default:         bus_rdata_o <= 8'h00;
      endcase
    end else begin
      bus_rdata_o <= 8'h00;
    end
  end
endmodule

// [rtl/irs_map.svh]
// constants for the interrupt and reset sequencer
`ifndef IRS_MAP_SVH
`define IRS_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define IRS_OFS_CTRL        4'h0
`define IRS_OFS_COUNT       4'h1
`define IRS_OFS_LOAD        4'h2
`define IRS_OFS_CPU         4'h3
`define IRS_OFS_STATUS      4'h4
// ****************************************
// timer control field positions
// ****************************************
`define IRS_TCR_REQ_BIT     7
`define IRS_TCR_MASK_BIT    6
`define IRS_TCR_EXT_BIT     5
`define IRS_TCR_STOP_BIT    4
`define IRS_TCR_UNUSED      4'hF
// ****************************************
// reset values
// ****************************************
`define IRS_RST_COUNT       8'hFF
`define IRS_RST_PRESC       7'h7F
// ****************************************
// vectors and timing
// ****************************************
`define IRS_VEC_RESET       12'hFFE
`define IRS_VEC_SWI         12'hFFC
`define IRS_VEC_EXT         12'hFFA
`define IRS_VEC_TIMER       12'hFF8
`define IRS_CLK_MHZ         50
`define IRS_MC_NS           1000
`define IRS_MC_DIV          ((`IRS_MC_NS * `IRS_CLK_MHZ) / 1000)
`define IRS_SEQ_CYCLES      11
`endif

// [rtl/irs_pkg.sv]
// types shared by the interrupt and reset sequencer
package irs_pkg;
  typedef enum logic [1:0] {
    IRS_SRC_EXT,
    IRS_SRC_TIMER,
    IRS_SRC_SWI
  } irs_src_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } irs_bus_t;

  typedef struct packed {
    logic        active;
    logic        stack_push;
    logic        stack_pop;
    logic [11:0] vector;
  } irs_seq_t;
endpackage

// [rtl/irs_sync.sv]
// two flop synchroniser for a level from outside the clock domain
module irs_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= RST_VAL;
      q_o      <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

// [rtl/irs_timer.sv]
// 8-bit down counter with prescaler and zero pulse
`include "irs_map.svh"
module irs_timer #(
  parameter int PRESC_BITS = 7
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       rst_seq_i,
  input  wire logic       mc_tick_i,
  input  wire logic       ext_tick_i,
  input  wire logic       ext_sel_i,
  input  wire logic       stop_i,
  input  wire logic [2:0] presc_sel_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_val_i,
  output logic      [7:0] count_o,
  output logic            zero_o
);
  logic [PRESC_BITS-1:0] presc_reg;
  logic                  src_tick;
  logic                  presc_tick;

  // source select then stop gate
  assign src_tick   = (ext_sel_i ? ext_tick_i : mc_tick_i) & ~stop_i;
  assign presc_tick = src_tick &
    (presc_sel_i == 3'h0 ? 1'b1 :
     presc_reg[presc_sel_i - 3'h1 +: 1] == 1'b0 &&
     (presc_reg & ((PRESC_BITS'(1) << presc_sel_i) - PRESC_BITS'(1)))
       == '0);

  // prescaler counts down from all ones
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presc_reg <= `IRS_RST_PRESC;
    end else if (rst_seq_i) begin
      presc_reg <= `IRS_RST_PRESC;
    end else if (src_tick) begin
      presc_reg <= presc_reg - PRESC_BITS'(1);
    end
  end

  // counter wraps from zero to all ones and keeps going
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_o <= `IRS_RST_COUNT;
      zero_o  <= 1'b0;
    end else if (rst_seq_i) begin
      count_o <= `IRS_RST_COUNT;
      zero_o  <= 1'b0;
    end else begin
      zero_o <= 1'b0;
      if (load_i) begin
        count_o <= load_val_i;
      end else if (presc_tick) begin
        count_o <= count_o - 8'h01;
        zero_o  <= (count_o == 8'h01);
      end
    end
  end
endmodule

// [dv/irs_chk.sv]
// port checker for the interrupt and reset sequencer
`include "irs_map.svh"
module irs_chk (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        instr_done_i,
  input  wire logic        swi_exec_i,
  input  wire logic        rti_exec_i,
  input  wire logic        cli_i,
  input  wire logic        bus_rd_i,
  input  wire logic [7:0]  bus_rdata_o,
  input  wire logic        mc_tick_o,
  input  wire logic        cpu_reset_o,
  input  wire logic        irq_mask_o,
  input  wire logic        seq_active_o,
  input  wire logic        stack_push_o,
  input  wire logic        stack_pop_o,
  input  wire logic [11:0] vector_o,
  input  wire logic        fetch_ok_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // machine ticks seen while a service runs, cleared between services
  logic [3:0] tick_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) tick_reg <= 4'h0;
    else if (!seq_active_o) tick_reg <= 4'h0;
    else if (mc_tick_o) tick_reg <= tick_reg + 4'h1;
  end
  // ****************************************
  // assertions
  // ****************************************
  a_rdata_idle: assert property (!$past(bus_rd_i)
    |-> bus_rdata_o == 8'h00) else $error("read data not idle");
  // a reset in mid service ends it early, so it is excluded
  a_seq_length: assert property ($fell(seq_active_o) && !cpu_reset_o
    |-> tick_reg inside {4'hA, 4'hB}) else $error("service length wrong");
  a_mask_on_seq: assert property ($rose(seq_active_o)
    |-> irq_mask_o && !fetch_ok_o) else $error("service not masked");
  a_push_in_seq: assert property (stack_push_o
    |-> seq_active_o && !$past(stack_push_o)) else $error("stray push");
  a_pop_after_rti: assert property (rti_exec_i
    |=> stack_pop_o ##1 !stack_pop_o) else $error("no pop pulse");
  a_reset_first: assert property (cpu_reset_o
    |-> !fetch_ok_o && irq_mask_o) else $error("reset not dominant");
  a_pin_reset: assert property ((!reset_pin_n_i)[*4]
    |=> cpu_reset_o) else $error("pin reset missed");
  // the mask output lags the flag by one cycle, so a clear or a start
  // in the previous cycle is excluded; the service shows two edges on
  a_masked_wait: assert property (irq_mask_o && instr_done_i
    && !swi_exec_i && !seq_active_o && !$past(instr_done_i)
    && !$past(cli_i) && !$past(rti_exec_i) |=> ##1 !seq_active_o)
    else $error("masked request serviced");
  a_trap_vector: assert property (instr_done_i && swi_exec_i
    && irq_mask_o && !seq_active_o && !cpu_reset_o && !$past(cli_i)
    && !$past(rti_exec_i) && !$past(instr_done_i)
    && $past(reset_pin_n_i) && $past(reset_pin_n_i, 2)
    |=> ##1 seq_active_o && vector_o == `IRS_VEC_SWI)
    else $error("trap lost");
  c_ext: cover property ($rose(seq_active_o) && vector_o == `IRS_VEC_EXT);
  c_tmr: cover property ($rose(seq_active_o) && vector_o == `IRS_VEC_TIMER);
  c_rst: cover property (seq_active_o && !reset_pin_n_i);
endmodule
bind irs_top irs_chk chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
  .reset_pin_n_i(reset_pin_n_i), .instr_done_i(instr_done_i),
  .swi_exec_i(swi_exec_i), .rti_exec_i(rti_exec_i), .cli_i(cli_i),
  .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .mc_tick_o(mc_tick_o),
  .cpu_reset_o(cpu_reset_o), .irq_mask_o(irq_mask_o),
  .seq_active_o(seq_active_o), .stack_push_o(stack_push_o),
  .stack_pop_o(stack_pop_o), .vector_o(vector_o), .fetch_ok_o(fetch_ok_o));

// [dv/irs_src.sv]
// model of the interrupt source and reset circuit outside the device
module irs_src #(
  parameter int HOLD = 40
) (
  input  wire logic clk_i,
  output logic      reset_pin_n_o,
  output logic      ext_irq_n_o,
  output logic      timer_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // power-up hold, then idle levels
  // ****************************************
  initial begin
    reset_pin_n_o = 1'b0;
    ext_irq_n_o = 1'b1;
    timer_pin_o = 1'b0;
    repeat (HOLD) @(posedge clk_i);
    reset_pin_n_o <= 1'b1;
  end
  // each level held well past the synchroniser so the detector re-arms
  task automatic ext_edge();
    ext_irq_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    ext_irq_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
  // one rising edge on the timer pin, each level held past the synchroniser
  task automatic timer_edge();
    timer_pin_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    timer_pin_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // low for longer than one machine cycle
  task automatic reset_low();
    reset_pin_n_o <= 1'b0;
    repeat (60) @(posedge clk_i);
    reset_pin_n_o <= 1'b1;
  endtask
endmodule

// [dv/testbench.sv]
// self-checking bench for the interrupt and reset sequencer
`include "irs_map.svh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, nrst_i = 1'b0, done_i = 1'b0, swi_i = 1'b0;
  logic rti_i = 1'b0, cli_i = 1'b0, sei_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic rpin_n, ext_n, tpin, tick, crst, mask, act, push, pop, fok;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wdata_i = 8'h00, rdata, d, d2;
  logic [11:0] vec;
  int miscompares = 0, cmp_count = 0, cyc = 0, n, i;
  always #10 clk_i = ~clk_i;
  irs_src src_u (.clk_i(clk_i), .reset_pin_n_o(rpin_n), .ext_irq_n_o(ext_n),
    .timer_pin_o(tpin));
  irs_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .reset_pin_n_i(rpin_n),
    .ext_irq_n_i(ext_n), .timer_pin_i(tpin), .instr_done_i(done_i),
    .swi_exec_i(swi_i), .rti_exec_i(rti_i), .cli_i(cli_i), .sei_i(sei_i),
    .bus_addr_i(addr_i), .bus_wdata_i(wdata_i), .bus_wr_i(wr_i),
    .bus_rd_i(rd_i), .bus_rdata_o(rdata), .mc_tick_o(tick),
    .cpu_reset_o(crst), .irq_mask_o(mask), .seq_active_o(act),
    .stack_push_o(push), .stack_pop_o(pop), .vector_o(vec), .fetch_ok_o(fok));
  // ****************************************
  // bus and core tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata;
    @(posedge clk_i);
  endtask
  task automatic pulse_mask(input logic set);
    sei_i <= set;
    cli_i <= !set;
    @(posedge clk_i);
    sei_i <= 1'b0;
    cli_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic done(input logic software_trap_instr);
    done_i <= 1'b1;
    swi_i <= software_trap_instr;
    @(posedge clk_i);
    done_i <= 1'b0;
    swi_i <= 1'b0;
    #1;
  endtask
  task automatic wait_tick();
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1 && n < 60);
  endtask
  // one whole service: start, pushes, end, return
  task automatic svc(input logic software_trap_instr, input logic [11:0] v);
    int p;
    p = 0;
    done(software_trap_instr);
    // outputs are registered: the service shows one edge after the start
    @(posedge clk_i);
    #1 p = int'(push);
    `CHK("seq_active", 1'b1, act)
    `CHK("vector", v, vec)
    `CHK("irq_mask", 1'b1, mask)
    for (n = 0; n < 800 && act === 1'b1; n++) begin
      @(posedge clk_i);
      #1 p += int'(push);
    end
    `CHK("pushes", 5, p)
    `CHK("seq_end", 1'b0, act)
    @(posedge clk_i);
    rti_i <= 1'b1;
    @(posedge clk_i);
    rti_i <= 1'b0;
    #1 `CHK("stack_pop", 1'b1, pop)
    @(posedge clk_i);
    #1 `CHK("irq_restore", 1'b0, mask)
    @(posedge clk_i);
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles the tests take
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1 `CHK("rst_vector", `IRS_VEC_RESET, vec)
    for (n = 0; n < 300 && crst !== 1'b0; n++) @(posedge clk_i);
    rd(`IRS_OFS_COUNT, d);
    `CHK("count_reset", `IRS_RST_COUNT, d)
    `CHK("reset_release", 1'b0, crst)
    rd(`IRS_OFS_CTRL, d);
    `CHK("ctrl_reset", {4'h4, `IRS_TCR_UNUSED}, d)
    $display("test reset done");
    wait_tick();
    wr(`IRS_OFS_COUNT, 8'h02);
    for (i = 0; i < 4; i++) begin
      wait_tick();
      repeat (5) @(posedge clk_i);
      rd(`IRS_OFS_COUNT, d);
      `CHK("count", 8'(8'h01 - i), d)
      rd(`IRS_OFS_COUNT, d);
      `CHK("count_again", 8'(8'h01 - i), d)
    end
    rd(`IRS_OFS_CTRL, d);
    `CHK("ctrl_flag", {4'hC, `IRS_TCR_UNUSED}, d)
    wr(`IRS_OFS_CTRL, 8'h4F);
    rd(`IRS_OFS_CTRL, d);
    `CHK("ctrl_clear", {4'h4, `IRS_TCR_UNUSED}, d)
    // stop control freezes the count, external source counts pin edges
    wr(`IRS_OFS_CTRL, 8'h5F);
    rd(`IRS_OFS_COUNT, d);
    repeat (120) @(posedge clk_i);
    rd(`IRS_OFS_COUNT, d2);
    `CHK("count_stopped", d, d2)
    wr(`IRS_OFS_CTRL, 8'h6F);
    rd(`IRS_OFS_COUNT, d);
    for (i = 0; i < 3; i++) src_u.timer_edge();
    rd(`IRS_OFS_COUNT, d2);
    `CHK("count_ext", 8'(d - 8'h03), d2)
    wr(`IRS_OFS_CTRL, 8'h4F);
    $display("test timer done");
    src_u.ext_edge();
    done(1'b0);
    @(posedge clk_i);
    #1 `CHK("masked_idle", 1'b0, act)
    `CHK("fetch_masked", 1'b1, fok)
    @(posedge clk_i);
    pulse_mask(1'b0);
    #1 `CHK("fetch_pending", 1'b0, fok)
    @(posedge clk_i);
    svc(1'b0, `IRS_VEC_EXT);
    $display("test masked done");
    pulse_mask(1'b1);
    wr(`IRS_OFS_CTRL, 8'h0F);
    wr(`IRS_OFS_COUNT, 8'h01);
    repeat (120) @(posedge clk_i);
    src_u.ext_edge();
    pulse_mask(1'b0);
    svc(1'b0, `IRS_VEC_EXT);
    svc(1'b0, `IRS_VEC_TIMER);
    wr(`IRS_OFS_CTRL, 8'h0F);
    $display("test priority done");
    src_u.ext_edge();
    svc(1'b1, `IRS_VEC_EXT);
    pulse_mask(1'b1);
    svc(1'b1, `IRS_VEC_SWI);
    $display("test trap done");
    src_u.ext_edge();
    done(1'b0);
    src_u.reset_low();
    #1 `CHK("pin_reset", 1'b1, crst)
    `CHK("reset_abort", 1'b0, act)
    `CHK("reset_vector", `IRS_VEC_RESET, vec)
    $display("test reset pin done");
    test_done();
  end
endmodule
